//--- mbcc_top.sv
// Top of the motor bridge chopper: APB registers, faults, output flops.
// Assumes host pins are synchronous to clk_sys; bridge 2 is the DC bridge.
// Contract
// - DC enabled, no trip, direction 1: A high, B low.
// - DC enabled, no trip, direction 0: A low, B high.
// - DC disabled in slow decay: both outputs low, brake.
// - Fast decay off-phase drives the reverse of the forward pattern.
// - DC slow decay trip drives both outputs low for the off-time.
// - Fast decay goes high impedance once zero current is seen.
// - Each on-phase drives the diagonal source and sink pair.
// - Unblanked comparator trip ends the on-phase and starts off-time.
// - Off-time lasts 30 us, then a new on-phase starts.
// - Comparator ignored for 1 us stepper, 3 us DC after switching.
// - Stepper off-time: fast decay 30.1 percent, then slow decay.
// - Fast to slow change forces drivers off about 600 ns.
// - Decay uses recirculation transistors until zero current is seen.
// - Recirculation stays active while DC enable is low.
// - Decay select high means slow decay, low fast decay.
// - Each stepper bridge takes two level bits and a direction.
// - Sleep input low disables logic and drives no outputs.
// - Short detect latches fault, outputs off; sleep or power clears.
// - Temperature, pump or supply faults disable outputs while present.
//
// Local design decisions: the APB slave port and the placing of the registers.
module mbcc_top
  import mbcc_pkg::*;
(
  input  wire logic                clk_sys,              // Core clock
  input  wire logic                sys_rst,              // Async reset
  input  wire logic [AW-1:0]       paddr,                // APB address
  input  wire logic                psel,                 // APB select
  input  wire logic                penable,              // APB enable
  input  wire logic                pwrite,               // APB write
  input  wire logic [31:0]         pwdata,               // APB write data
  output logic      [31:0]         prdata,               // APB read data
  output logic                     pready,               // APB ready
  output logic                     pslverr,              // APB error
  input  wire logic                low_power_request_n,  // Sleep, low
  input  wire logic                dc_enable,            // DC drive enable
  input  wire logic                dc_dir,               // DC direction
  input  wire logic                dc_slow_decay,        // DC decay select
  input  wire logic [1:0]          step_dir,             // Stepper direction
  input  wire logic [1:0]          step_level_bit_low,   // Level code bit 0
  input  wire logic [1:0]          step_level_bit_high,  // Level code bit 1
  input  wire logic [N_BR-1:0]     sense_trip,           // Comparator tripped
  input  wire logic [N_BR-1:0]     zero_current,         // Near-zero current
  input  wire logic                short_detect,         // Output short seen
  input  wire logic                over_temp,            // Thermal fault
  input  wire logic                gate_pump_supply_low, // Pump voltage low
  input  wire logic                supply_low_lockout,   // Load supply low
  output logic      [N_BR-1:0]     bridge_output_a,      // Half A level
  output logic      [N_BR-1:0]     bridge_output_a_en,   // Half A driven
  output logic      [N_BR-1:0]     bridge_output_b,      // Half B level
  output logic      [N_BR-1:0]     bridge_output_b_en,   // Half B driven
  output logic      [7:0]          step_level_pct_0,     // Bridge 0 level
  output logic      [7:0]          step_level_pct_1,     // Bridge 1 level
  output logic                     short_fault_latch     // Latched fault
);
  typedef struct packed {
    logic            fault;
    logic            sr_en;
    logic [N_BR-1:0] a_lvl;
    logic [N_BR-1:0] a_en;
    logic [N_BR-1:0] b_lvl;
    logic [N_BR-1:0] b_en;
    logic [7:0]      pct0;
    logic [7:0]      pct1;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } mbcc_top_st_t;
  mbcc_top_st_t cur, next_cur;

  logic [N_BR-1:0] chop_a_lvl;
  logic [N_BR-1:0] chop_a_en;
  logic [N_BR-1:0] chop_b_lvl;
  logic [N_BR-1:0] chop_b_en;
  logic [N_BR-1:0] chop_on;
  logic            drive_ok;
  logic            access;
  logic [31:0]     stat_word;

  function automatic logic [7:0] level_pct(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: level_pct = PCT_100;
      2'b01: level_pct = PCT_66;
      2'b10: level_pct = PCT_33;
      default: level_pct = PCT_0;
    endcase
  endfunction

  // Faults and sleep gate every bridge; chopper state resets with them
  assign drive_ok = low_power_request_n && !cur.fault && !over_temp
                    && !gate_pump_supply_low && !supply_low_lockout;

  for (genvar i = 0; i < N_BR; i++)
  begin : g_br
    mbcc_chop_if cif ();
    if (i == DC_IDX)
    begin : g_dc
      assign cif.en = drive_ok && dc_enable;
      assign cif.dir = dc_dir;
      assign cif.slow_sel = dc_slow_decay;
    end
    else
    begin : g_st
      // Zero-current level code parks the bridge
      assign cif.en = drive_ok
                      && !(step_level_bit_high[i] && step_level_bit_low[i]);
      assign cif.dir = step_dir[i];
      assign cif.slow_sel = 1'b0;
    end
    assign cif.sr_en = cur.sr_en;
    assign cif.trip = sense_trip[i];
    assign cif.zero = zero_current[i];
    assign chop_a_lvl[i] = cif.a_lvl;
    assign chop_a_en[i] = cif.a_en;
    assign chop_b_lvl[i] = cif.b_lvl;
    assign chop_b_en[i] = cif.b_en;
    assign chop_on[i] = cif.on_phase;
    mbcc_chopper #(
      .IS_DC     (i == DC_IDX),
      .BLANK_CYC ((i == DC_IDX) ? BLANK_DC_CYC : BLANK_ST_CYC)
    ) u_chop (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .c       (cif.chop)
    );
  end

  assign access = psel && penable && !cur.pready;
  assign stat_word = {25'h0, chop_on, supply_low_lockout, gate_pump_supply_low,
                      over_temp, cur.fault};

  always_comb
  begin
    next_cur = cur;
    // A new short wins over a sleep clear in the same cycle
    next_cur.fault = short_detect || (cur.fault && low_power_request_n);
    next_cur.a_lvl = chop_a_lvl;
    next_cur.b_lvl = chop_b_lvl;
    next_cur.a_en = drive_ok ? chop_a_en : '0;
    next_cur.b_en = drive_ok ? chop_b_en : '0;
    next_cur.pct0 = level_pct(step_level_bit_high[0], step_level_bit_low[0]);
    next_cur.pct1 = level_pct(step_level_bit_high[1], step_level_bit_low[1]);
    // One wait state so every APB output comes from a flop
    next_cur.pready = access;
    next_cur.pslverr = 1'b0;
    next_cur.prdata = '0;
    if (access)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          if (pwrite)
            next_cur.sr_en = pwdata[CTRL_SR];
          else
            next_cur.prdata = {31'h0, cur.sr_en};
        end
        ADDR_STAT:
        begin
          if (!pwrite)
            next_cur.prdata = stat_word;
        end
        default:
          next_cur.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cur <= '0;
      cur.sr_en <= CTRL_SR_RST;
    end
    else
      cur <= next_cur;
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign bridge_output_a = cur.a_lvl;
  assign bridge_output_a_en = cur.a_en;
  assign bridge_output_b = cur.b_lvl;
  assign bridge_output_b_en = cur.b_en;
  assign step_level_pct_0 = cur.pct0;
  assign step_level_pct_1 = cur.pct1;
  assign short_fault_latch = cur.fault;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_dc_on;
    drive_ok && dc_enable && chop_on[DC_IDX];
  endsequence

  a_fault_set: assert property (short_detect |=> short_fault_latch)
    else $error("short did not latch fault");
  a_fault_off: assert property (short_fault_latch
    |=> bridge_output_a_en == '0 && bridge_output_b_en == '0)
    else $error("outputs driven while fault latched");
  a_sleep_clear: assert property (!low_power_request_n && !short_detect
    |=> !short_fault_latch)
    else $error("sleep did not clear fault");
  a_sleep_off: assert property (!low_power_request_n
    |=> bridge_output_a_en == '0 && bridge_output_b_en == '0)
    else $error("outputs driven in sleep");
  a_shutdown_off: assert property (over_temp || gate_pump_supply_low || supply_low_lockout
    |=> bridge_output_a_en == '0 && bridge_output_b_en == '0)
    else $error("outputs driven during shutdown");
  a_dc_drive: assert property (s_dc_on |=> bridge_output_a[DC_IDX] == $past(dc_dir)
    && bridge_output_b[DC_IDX] != $past(dc_dir)
    && bridge_output_a_en[DC_IDX] && bridge_output_b_en[DC_IDX])
    else $error("DC on-phase pattern wrong");
  a_dc_brake: assert property (drive_ok && !dc_enable && dc_slow_decay
    |=> !bridge_output_a[DC_IDX] && !bridge_output_b[DC_IDX]
    && bridge_output_a_en[DC_IDX] && bridge_output_b_en[DC_IDX])
    else $error("DC brake pattern wrong");
  a_level_zero: assert property (step_level_bit_high[0] && step_level_bit_low[0]
    |=> step_level_pct_0 == PCT_0)
    else $error("zero level code not decoded");
  a_apb_answer: assert property (s_access |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
endmodule

//--- mbcc_pkg.sv
// Shared constants for the bridge chopper: register map, timing counts.
// Assumes a single core clock; counts derive from CLK_HZ.
package mbcc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MHZ = CLK_HZ / 1_000_000;
  localparam int T_OFF_NS = 30000;
  localparam int T_BLANK_ST_NS = 1000;
  localparam int T_BLANK_DC_NS = 3000;
  localparam int T_DEAD_NS = 600;
  localparam int FD_PERMILLE = 301;
  localparam int CNT_W = 10;
  // Off-time and dead time are least times: round up
  localparam int OFF_N = (T_OFF_NS * MHZ + 999) / 1000;
  localparam int DEAD_N = (T_DEAD_NS * MHZ + 999) / 1000;
  // Blank times are nominal; fast portion of off-time rounds down
  localparam int BST_N = (T_BLANK_ST_NS * MHZ) / 1000;
  localparam int BDC_N = (T_BLANK_DC_NS * MHZ) / 1000;
  localparam int FD_N = (OFF_N * FD_PERMILLE) / 1000;
  localparam logic [CNT_W-1:0] OFF_CYC = CNT_W'(OFF_N);
  localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'(DEAD_N);
  localparam logic [CNT_W-1:0] BLANK_ST_CYC = CNT_W'(BST_N);
  localparam logic [CNT_W-1:0] BLANK_DC_CYC = CNT_W'(BDC_N);
  localparam logic [CNT_W-1:0] FD_CYC = CNT_W'(FD_N);
  localparam int N_BR = 3;
  localparam int DC_IDX = 2;
  localparam int AW = 12;
  localparam logic [AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [AW-1:0] ADDR_STAT = 12'h004;
  localparam int CTRL_SR = 0;
  localparam logic CTRL_SR_RST = 1'b1;
  localparam logic [7:0] PCT_100 = 8'h64;
  localparam logic [7:0] PCT_66 = 8'h42;
  localparam logic [7:0] PCT_33 = 8'h21;
  localparam logic [7:0] PCT_0 = 8'h00;
  typedef enum logic [1:0] {CH_ON, CH_FAST, CH_DEAD, CH_SLOW} mbcc_chop_st_t;
endpackage

//--- mbcc_chop_if.sv
// Links the top controller to one bridge chopper.
// Assumes both ends share clk_sys.
interface mbcc_chop_if;
  logic en;
  logic dir;
  logic slow_sel;
  logic sr_en;
  logic trip;
  logic zero;
  logic a_lvl;
  logic a_en;
  logic b_lvl;
  logic b_en;
  logic on_phase;
  modport ctl (output en, dir, slow_sel, sr_en, trip, zero,
               input a_lvl, a_en, b_lvl, b_en, on_phase);
  modport chop (input en, dir, slow_sel, sr_en, trip, zero,
                output a_lvl, a_en, b_lvl, b_en, on_phase);
endinterface

//--- mbcc_chopper.sv
// Fixed off-time chopper for one full bridge, with blanking and decay.
// Assumes en already folds in faults, sleep and drive enable.
module mbcc_chopper
  import mbcc_pkg::*;
#(
  parameter bit                IS_DC     = 1'b0,
  parameter logic [CNT_W-1:0]  BLANK_CYC = BLANK_ST_CYC
)(
  input  wire logic  clk_sys,  // Core clock
  input  wire logic  sys_rst,  // Async reset
  mbcc_chop_if.chop  c         // Controller side
);
  typedef struct packed {
    mbcc_chop_st_t    st;
    logic [CNT_W-1:0] off_cnt;
    logic [CNT_W-1:0] blank_cnt;
    logic             zero_seen;
  } mbcc_ch_t;
  mbcc_ch_t cur, next_cur;

  always_comb
  begin
    next_cur = cur;
    if (!c.en)
    begin
      next_cur.st = CH_ON;
      next_cur.off_cnt = '0;
      next_cur.blank_cnt = '0;
      next_cur.zero_seen = cur.zero_seen | c.zero;
    end
    else
    begin
      unique case (cur.st)
        CH_ON:
        begin
          next_cur.zero_seen = 1'b0;
          if (cur.blank_cnt < BLANK_CYC)
            next_cur.blank_cnt = cur.blank_cnt + 1'b1;
          else if (c.trip)
          begin
            next_cur.off_cnt = '0;
            next_cur.st = (!IS_DC || !c.slow_sel) ? CH_FAST : CH_SLOW;
          end
        end
        CH_FAST, CH_DEAD, CH_SLOW:
        begin
          next_cur.off_cnt = cur.off_cnt + 1'b1;
          if (cur.st != CH_DEAD)
            next_cur.zero_seen = cur.zero_seen | c.zero;
          if (cur.off_cnt == OFF_CYC - 1'b1)
          begin
            next_cur.st = CH_ON;
            next_cur.blank_cnt = '0;
          end
          else if (!IS_DC && cur.st == CH_FAST && cur.off_cnt == FD_CYC - 1'b1)
            next_cur.st = CH_DEAD;
          else if (cur.st == CH_DEAD && cur.off_cnt == FD_CYC + DEAD_CYC - 1'b1)
            next_cur.st = CH_SLOW;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cur <= '{st: CH_ON, off_cnt: '0, blank_cnt: '0, zero_seen: 1'b0};
    else
      cur <= next_cur;
  end

  // Output pattern; the top registers it before the pins
  always_comb
  begin
    c.on_phase = c.en && cur.st == CH_ON;
    c.a_lvl = !c.dir;
    c.b_lvl = c.dir;
    c.a_en = 1'b0;
    c.b_en = 1'b0;
    if (!c.en)
    begin
      if (IS_DC && c.slow_sel)
      begin
        c.a_lvl = 1'b0;
        c.b_lvl = 1'b0;
        c.a_en = 1'b1;
        c.b_en = 1'b1;
      end
      else if (IS_DC)
      begin
        c.a_en = !cur.zero_seen;
        c.b_en = !cur.zero_seen;
      end
    end
    else
    begin
      unique case (cur.st)
        CH_ON:
        begin
          c.a_lvl = c.dir;
          c.b_lvl = !c.dir;
          c.a_en = 1'b1;
          c.b_en = 1'b1;
        end
        CH_FAST:
        begin
          c.a_en = c.sr_en && !cur.zero_seen;
          c.b_en = c.sr_en && !cur.zero_seen;
        end
        CH_DEAD:
        begin
          c.a_en = 1'b0;
          c.b_en = 1'b0;
        end
        CH_SLOW:
        begin
          c.a_lvl = 1'b0;
          c.b_lvl = 1'b0;
          c.a_en = c.sr_en && !cur.zero_seen;
          c.b_en = c.sr_en && !cur.zero_seen;
        end
      endcase
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_trip_taken;
    c.en && cur.st == CH_ON && cur.blank_cnt == BLANK_CYC && c.trip;
  endsequence
  sequence s_fd_end;
    !IS_DC && c.en && cur.st == CH_FAST && cur.off_cnt == FD_CYC - 1'b1;
  endsequence
  a_trip_exit: assert property (s_trip_taken |=> cur.st != CH_ON && cur.off_cnt == 0)
    else $error("trip did not end on-phase");
  a_blank_hold: assert property (c.en && cur.st == CH_ON && cur.blank_cnt < BLANK_CYC
    |=> cur.st == CH_ON)
    else $error("trip taken inside blank time");
  a_off_end: assert property (c.en && cur.st != CH_ON && cur.off_cnt == OFF_CYC - 1'b1
    |=> cur.st == CH_ON && cur.blank_cnt == 0)
    else $error("off-time length wrong");
  a_fast_dead: assert property (s_fd_end
    |=> cur.st == CH_DEAD && !c.a_en && !c.b_en)
    else $error("fast portion did not enter dead time");
  a_dead_len: assert property (c.en && cur.st == CH_DEAD
    && cur.off_cnt == FD_CYC + DEAD_CYC - 1'b1 |=> cur.st == CH_SLOW)
    else $error("dead time length wrong");
endmodule

//--- mbcc_host_model.sv
// Host controller model: puts the bench's command word on the logic pins.
// Assumes the word changes just after a clk_sys edge; pins follow one edge later.
module mbcc_host_model (
  input  wire logic       clk_sys,  // Core clock
  input  wire logic [9:0] cmd,      // Wanted pin levels
  output logic            sleep_n,  // Sleep request, low
  output logic            en,       // DC enable
  output logic            dir,      // DC direction
  output logic            slow,     // DC decay select
  output logic [1:0]      sdir,     // Stepper directions
  output logic [1:0]      lo,       // Level bit 0 per stepper
  output logic [1:0]      hi        // Level bit 1 per stepper
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins are defined from time zero, awake, DC bridge off, steppers at full level
  initial {sleep_n, en, dir, slow, sdir, lo, hi} = 10'h200;
  // Registered so pins move only on clk_sys edges, after the design has sampled them
  always @(posedge clk_sys)
    {sleep_n, en, dir, slow, sdir, lo, hi} <= cmd;
endmodule

//--- mbcc_tb_top.sv
// Self-checking bench for the bridge chopper top.
// Assumes 20 MHz core clock and the package's cycle counts.
module mbcc_tb_top import mbcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  logic [AW-1:0]   paddr = 12'h000;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]     pwdata = 32'h0, prdata, rd;
  logic            pready, pslverr, er, latch, short_det = 1'b0;
  logic [9:0]      cmd = 10'h200;
  logic            sleep_n, en, dir, slow;
  logic [1:0]      sdir, lo, hi;
  logic [2:0]      trip = 3'h0, zero = 3'h0, flt = 3'h0, a, b, ae, be;
  logic [7:0]      pct0, pct1;
  int              err_count = 0, total_checks = 0, cyc_n = 0, t0;
  logic [7:0]      lv [4] = '{PCT_100, PCT_66, PCT_33, PCT_0};
  // Rows: en, dir, slow, then expected a, b, a driven, b driven
  logic [6:0]      dc_rows [8] = '{7'h7b, 7'h6b, 7'h57, 7'h47, 7'h33, 7'h13, 7'h27, 7'h0b};

  mbcc_host_model host (.clk_sys(clk_sys), .cmd(cmd), .sleep_n(sleep_n), .en(en), .dir(dir),
    .slow(slow), .sdir(sdir), .lo(lo), .hi(hi));
  mbcc_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power_request_n(sleep_n), .dc_enable(en), .dc_dir(dir),
    .dc_slow_decay(slow), .step_dir(sdir), .step_level_bit_low(lo), .step_level_bit_high(hi),
    .sense_trip(trip), .zero_current(zero), .short_detect(short_det), .over_temp(flt[0]),
    .gate_pump_supply_low(flt[1]), .supply_low_lockout(flt[2]), .bridge_output_a(a),
    .bridge_output_a_en(ae), .bridge_output_b(b), .bridge_output_b_en(be),
    .step_level_pct_0(pct0), .step_level_pct_1(pct1), .short_fault_latch(latch));

  always #25 clk_sys = ~clk_sys;

  // A hang ends the run as a mismatch
  always @(posedge clk_sys)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reads at an edge see the values settled before it
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic upto(input int k);
    while (cyc_n < t0 + k) w(1);
  endtask

  function automatic logic [31:0] br(input int i);
    return {28'h0, a[i], b[i], ae[i], be[i]};
  endfunction

  task automatic pulse_trip(input int i);
    trip[i] <= 1'b1;
    w(1);
    trip[i] <= 1'b0;
  endtask

  task automatic apb(input logic [AW-1:0] ad, input logic wr, input logic [31:0] wd);
    w(1);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= wr;
    pwdata <= wd;
    w(1);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never gets an answer
    do
      w(1);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    w(8);
    sys_rst <= 1'b0;
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_reset", rd, 32'h1);
    w(1);
    chk("pready_pulse", {31'h0, pready}, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_write", rd, 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h1);
    apb(12'h008, 1'b0, 32'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h80000000);
    for (int k = 0; k < 4; k++)
    begin
      cmd <= {4'b1000, 2'b00, k[1], k[0], k[0], k[1]};
      w(4);
      chk("level_pct", {24'h0, pct0}, {24'h0, lv[k]});
      chk("level_pct1", {24'h0, pct1}, {24'h0, lv[{k[0], k[1]}]});
    end
    foreach (dc_rows[r])
    begin
      cmd <= {1'b1, dc_rows[r][6:4], 6'h0f};
      w(8);
      chk("dc_table", br(2), {28'h0, dc_rows[r][3:0]});
    end
    // Stepper 0 full level, stepper 1 level code for zero current
    cmd <= 10'h25a;
    w(40);
    chk("st_on", br(0), 32'hb);
    chk("st_zero_level", {30'h0, ae[1], be[1]}, 32'h0);
    pulse_trip(0);
    t0 = cyc_n;
    upto(10);
    chk("st_fast", br(0), 32'h7);
    upto(187);
    chk("st_dead", br(0) & 32'h3, 32'h0);
    upto(300);
    chk("st_slow", br(0), 32'h3);
    zero[0] <= 1'b1;
    upto(306);
    chk("st_zero_cut", br(0) & 32'h3, 32'h0);
    zero[0] <= 1'b0;
    upto(604);
    pulse_trip(0);
    upto(620);
    chk("st_blanked", br(0), 32'hb);
    upto(640);
    pulse_trip(0);
    upto(650);
    chk("st_chop", br(0), 32'h7);
    cmd <= 10'h3cf;
    w(80);
    pulse_trip(2);
    w(8);
    chk("dc_slow_chop", br(2), 32'h3);
    cmd <= 10'h38f;
    w(620);
    pulse_trip(2);
    w(4);
    chk("dc_blanked", br(2), 32'hb);
    w(75);
    pulse_trip(2);
    w(8);
    chk("dc_fast_chop", br(2), 32'h7);
    zero[2] <= 1'b1;
    w(5);
    chk("dc_zero_hiz", br(2) & 32'h3, 32'h0);
    zero[2] <= 1'b0;
    w(700);
    for (int i = 0; i < 3; i++)
    begin
      flt[i] <= 1'b1;
      w(5);
      chk("fault_off", br(2) & 32'h3, 32'h0);
      flt[i] <= 1'b0;
      w(80);
      chk("fault_resume", br(2), 32'hb);
    end
    short_det <= 1'b1;
    w(1);
    short_det <= 1'b0;
    w(20);
    chk("short_latch", {29'h0, latch, ae[2], be[2]}, 32'h4);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk("stat_fault", rd, 32'h1);
    cmd <= 10'h1cf;
    w(5);
    chk("sleep", {25'h0, latch, ae, be}, 32'h0);
    cmd <= 10'h3cf;
    w(80);
    chk("wake", br(2), 32'hb);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    sys_rst <= 1'b1;
    w(2);
    chk("reset_off", {25'h0, ae, be, latch}, 32'h0);
    sys_rst <= 1'b0;
    w(3);
    chk("reset_resume", br(2), 32'hb);
    apb(ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_after_reset", rd, {31'h0, CTRL_SR_RST});
    give_verdict();
  end
endmodule
